// file: hdl/uebc_top.sv
// Operation
// - Stall bit in ack-OUT mode stalls OUT packets.
// - Stall bit in ack-IN mode stalls IN packets.
// - NAK-interrupt enable also raises NAK interrupts.
// - ACKed transaction sets the acked flag.
// - Mode steers engine; hardware updates mode.
// - Disabled single-ended outputs: D+/D- high, SE0 low.
// - Enabled single-ended outputs follow the bus.
// - Disabled: line-state bits read as ones.
// - Boost bit selects oscillator DAC accuracy mode.
// - Clock gate off: clocks low, no response.
// - Clock gate off: writes ignored except trim/misc.
// - Clock gate on: clocks run, normal response.
`timescale 1ns/10ps
`include "uebc_regs.svh"

module uebc_top
    import uebc_pkg::*;
#(
    parameter int NUM_EP = 8,
    parameter int EP_W   = 3
) (
    // Clock and reset
    input  wire logic            sys_clk_i,
    input  wire logic            sys_rst_i,
    // Register port
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic [7:0]      reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    output logic      [7:0]      reg_rdata_o,
    // Token from the serial interface engine
    input  wire logic            sie_tok_valid_i,
    input  wire logic [EP_W-1:0] sie_tok_ep_i,
    input  wire logic            sie_tok_in_i,
    // Transaction completion from the serial interface engine
    input  wire logic            sie_done_valid_i,
    input  wire logic [EP_W-1:0] sie_done_ep_i,
    input  wire logic            sie_done_ack_i,
    input  wire logic            sie_done_nak_i,
    // Handshake answer to the serial interface engine
    output logic                 sie_hs_valid_o,
    output logic      [1:0]      sie_hs_code_o,
    // Pad cell
    input  wire logic            usb_dp_i,
    input  wire logic            usb_dm_i,
    output logic                 dplus_out_level_o,
    output logic                 dminus_out_level_o,
    output logic                 se0_receive_out_o,
    // Clock gate, oscillator control and interrupt
    output logic                 usb_clk_en_o,
    output logic                 osc_accuracy_boost_o,
    output logic      [7:0]      osc_trim_o,
    output logic      [7:0]      osc_trim_two_o,
    output logic                 irq_o
);

    // Synchronised pad levels.
    logic dp_meta_q;
    logic dp_sync_q;
    logic dm_meta_q;
    logic dm_sync_q;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dp_meta_q <= 1'b1;
            dp_sync_q <= 1'b1;
            dm_meta_q <= 1'b0;
            dm_sync_q <= 1'b0;
        end else begin
            dp_meta_q <= usb_dp_i;
            dp_sync_q <= dp_meta_q;
            dm_meta_q <= usb_dm_i;
            dm_sync_q <= dm_meta_q;
        end
    end

    // Miscellaneous control, trim and interrupt registers.
    logic [2:0] misc_q;
    logic [2:0] misc_d;
    logic [7:0] trim_q;
    logic [7:0] trim_d;
    logic [7:0] trim2_q;
    logic [7:0] trim2_d;
    logic [7:0] int_stat_q;
    logic [7:0] int_stat_d;
    logic [7:0] int_mask_q;
    logic [7:0] int_mask_d;
    logic       clk_on;
    logic       se_en;
    logic       usb_wr;
    logic [7:0] ep_events;

    assign clk_on = misc_q[`UEBC_MISC_CLKON_BIT];
    assign se_en  = misc_q[`UEBC_MISC_SEEN_BIT];
    // Registers of the USB block only take writes while its clocks run.
    assign usb_wr = reg_wr_i && clk_on;

    always_comb begin
        misc_d     = misc_q;
        trim_d     = trim_q;
        trim2_d    = trim2_q;
        int_mask_d = int_mask_q;
        int_stat_d = int_stat_q;
        if (reg_wr_i && reg_addr_i == `UEBC_MISC_OFS) begin
            misc_d = reg_wdata_i[2:0];
        end
        // The oscillator trims stay writable so the part can be tuned while gated.
        if (reg_wr_i && reg_addr_i == `UEBC_OSC_TRIM_OFS) begin
            trim_d = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `UEBC_OSC_TRIM2_OFS) begin
            trim2_d = reg_wdata_i;
        end
        if (usb_wr && reg_addr_i == `UEBC_INT_MASK_OFS) begin
            int_mask_d = reg_wdata_i;
        end
        if (usb_wr && reg_addr_i == `UEBC_INT_STAT_OFS) begin
            int_stat_d = int_stat_q & ~reg_wdata_i;
        end
        // A new event in the clearing cycle survives the clear.
        int_stat_d = int_stat_d | ep_events;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            misc_q     <= `UEBC_MISC_RST;
            trim_q     <= `UEBC_TRIM_RST;
            trim2_q    <= `UEBC_TRIM_RST;
            int_stat_q <= `UEBC_INT_RST;
            int_mask_q <= `UEBC_INT_RST;
        end else begin
            misc_q     <= misc_d;
            trim_q     <= trim_d;
            trim2_q    <= trim2_d;
            int_stat_q <= int_stat_d;
            int_mask_q <= int_mask_d;
        end
    end

    // Endpoint control registers, one instance per endpoint.
    logic [7:0] ep_ctrl [NUM_EP];
    logic [7:0] ep_rd_hit;
    logic       done_en;

    // Traffic is ignored entirely while the block clocks are stopped.
    assign done_en = sie_done_valid_i && clk_on;

    for (genvar i = 0; i < 8; i++) begin : g_ep
        if (i < NUM_EP) begin : g_on
            logic sel;
            assign sel = reg_addr_i == 8'(`UEBC_EP_BASE_OFS + i);
            assign ep_rd_hit[i] = reg_rd_i && sel;
            uebc_ep_ctrl u_ep (
                .sys_clk_i (sys_clk_i),
                .sys_rst_i (sys_rst_i),
                .wr_i      (usb_wr && sel),
                .rd_i      (reg_rd_i && sel),
                .wdata_i   (reg_wdata_i),
                .done_i    (done_en && sie_done_ep_i == EP_W'(i)),
                .ack_i     (sie_done_ack_i),
                .nak_i     (sie_done_nak_i),
                .ctrl_o    (ep_ctrl[i]),
                .event_o   (ep_events[i])
            );
        end else begin : g_off
            assign ep_rd_hit[i] = 1'b0;
            assign ep_events[i] = 1'b0;
        end
    end

    // Handshake decision.
    logic       hs_valid_q;
    logic       hs_valid_d;
    logic [1:0] hs_code_q;
    logic [1:0] hs_code_d;
    logic [7:0] tok_ctrl;
    logic       tok_stall;

    assign tok_ctrl  = ep_ctrl[sie_tok_ep_i];
    assign tok_stall = tok_ctrl[`UEBC_EP_STALL_BIT];

    always_comb begin
        hs_valid_d = 1'b0;
        hs_code_d  = UEBC_HS_NAK;
        // Stall is only consulted in the two ack modes.
        if (sie_tok_valid_i && clk_on) begin
            case (tok_ctrl[`UEBC_EP_MODE_MSB:`UEBC_EP_MODE_LSB])
                UEBC_MODE_ACK_OUT: begin
                    hs_valid_d = !sie_tok_in_i;
                    hs_code_d  = tok_stall ? UEBC_HS_STALL : UEBC_HS_ACK;
                end
                UEBC_MODE_ACK_IN: begin
                    hs_valid_d = sie_tok_in_i;
                    hs_code_d  = tok_stall ? UEBC_HS_STALL : UEBC_HS_ACK;
                end
                UEBC_MODE_NAK_OUT: begin
                    hs_valid_d = !sie_tok_in_i;
                    hs_code_d  = UEBC_HS_NAK;
                end
                UEBC_MODE_NAK_IN: begin
                    hs_valid_d = sie_tok_in_i;
                    hs_code_d  = UEBC_HS_NAK;
                end
                default: begin
                    hs_valid_d = 1'b0;
                    hs_code_d  = UEBC_HS_NAK;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            hs_valid_q <= 1'b0;
            hs_code_q  <= 2'h0;
        end else begin
            hs_valid_q <= hs_valid_d;
            hs_code_q  <= hs_code_d;
        end
    end

    // Pad outputs, line state and block-level controls.
    logic       dpo_q;
    logic       dpo_d;
    logic       dmo_q;
    logic       dmo_d;
    logic       se0_q;
    logic       se0_d;
    logic       clk_en_q;
    logic       boost_q;
    logic       irq_q;
    logic       irq_d;
    logic [1:0] line_state;

    always_comb begin
        if (se_en) begin
            dpo_d = dp_sync_q;
            dmo_d = dm_sync_q;
            se0_d = !dp_sync_q && !dm_sync_q;
        end else begin
            dpo_d = 1'b1;
            dmo_d = 1'b1;
            se0_d = 1'b0;
        end
        line_state = se_en ? {dp_sync_q, dm_sync_q} : 2'b11;
        irq_d      = |(int_stat_q & int_mask_q);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dpo_q    <= 1'b1;
            dmo_q    <= 1'b1;
            se0_q    <= 1'b0;
            clk_en_q <= 1'b0;
            boost_q  <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            dpo_q    <= dpo_d;
            dmo_q    <= dmo_d;
            se0_q    <= se0_d;
            clk_en_q <= misc_d[`UEBC_MISC_CLKON_BIT];
            boost_q  <= misc_d[`UEBC_MISC_BOOST_BIT];
            irq_q    <= irq_d;
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `UEBC_MISC_OFS:      rdata_d = {5'h00, misc_q};
                `UEBC_INT_STAT_OFS:  rdata_d = int_stat_q;
                `UEBC_INT_MASK_OFS:  rdata_d = int_mask_q;
                `UEBC_OSC_TRIM_OFS:  rdata_d = trim_q;
                `UEBC_OSC_TRIM2_OFS: rdata_d = trim2_q;
                `UEBC_IO_CTRL1_OFS:  rdata_d = {6'h00, line_state};
                default: begin
                    rdata_d = 8'h00;
                    for (int k = 0; k < NUM_EP; k++) begin
                        if (ep_rd_hit[k]) begin
                            rdata_d = ep_ctrl[k];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o          = rdata_q;
    assign sie_hs_valid_o       = hs_valid_q;
    assign sie_hs_code_o        = hs_code_q;
    assign dplus_out_level_o    = dpo_q;
    assign dminus_out_level_o   = dmo_q;
    assign se0_receive_out_o    = se0_q;
    assign usb_clk_en_o         = clk_en_q;
    assign osc_accuracy_boost_o = boost_q;
    assign osc_trim_o           = trim_q;
    assign osc_trim_two_o       = trim2_q;
    assign irq_o                = irq_q;

endmodule : uebc_top

// file: hdl/uebc_regs.svh
`ifndef UEBC_REGS_SVH
`define UEBC_REGS_SVH

// Register offsets on the 8-bit register port.
`define UEBC_MISC_OFS      8'hBD
`define UEBC_EP_BASE_OFS   8'h10
`define UEBC_INT_STAT_OFS  8'h20
`define UEBC_INT_MASK_OFS  8'h21
`define UEBC_OSC_TRIM_OFS  8'h22
`define UEBC_OSC_TRIM2_OFS 8'h23
`define UEBC_IO_CTRL1_OFS  8'h24

// Endpoint control field positions.
`define UEBC_EP_STALL_BIT  7
`define UEBC_EP_NAKEN_BIT  5
`define UEBC_EP_ACKED_BIT  4
`define UEBC_EP_MODE_MSB   3
`define UEBC_EP_MODE_LSB   0

// Miscellaneous control field positions.
`define UEBC_MISC_SEEN_BIT  2
`define UEBC_MISC_BOOST_BIT 1
`define UEBC_MISC_CLKON_BIT 0

// Reset values.
`define UEBC_EP_RST        8'h00
`define UEBC_MISC_RST      3'h0
`define UEBC_TRIM_RST      8'h00
`define UEBC_INT_RST       8'h00

`endif

// file: hdl/uebc_pkg.sv
package uebc_pkg;

    // Endpoint mode field encodings.
    typedef enum logic [3:0] {
        UEBC_MODE_DISABLE = 4'h0,
        UEBC_MODE_NAK_OUT = 4'h1,
        UEBC_MODE_ACK_OUT = 4'h2,
        UEBC_MODE_NAK_IN  = 4'h3,
        UEBC_MODE_ACK_IN  = 4'h4
    } uebc_mode_t;

    // Handshake answer given to the serial interface engine.
    typedef enum logic [1:0] {
        UEBC_HS_ACK   = 2'h0,
        UEBC_HS_NAK   = 2'h1,
        UEBC_HS_STALL = 2'h2
    } uebc_hs_t;

endpackage : uebc_pkg

// file: hdl/uebc_ep_ctrl.sv
`timescale 1ns/10ps
`include "uebc_regs.svh"

module uebc_ep_ctrl
    import uebc_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    // Register access
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    // Transaction completion from the serial interface engine
    input  wire logic       done_i,
    input  wire logic       ack_i,
    input  wire logic       nak_i,
    // State
    output logic      [7:0] ctrl_o,
    output logic            event_o
);

    logic       stall_q;
    logic       stall_d;
    logic       naken_q;
    logic       naken_d;
    logic       acked_q;
    logic       acked_d;
    logic [3:0] mode_q;
    logic [3:0] mode_d;

    localparam logic [7:0] EP_RST_VAL = `UEBC_EP_RST;

    always_comb begin
        stall_d = stall_q;
        naken_d = naken_q;
        acked_d = acked_q;
        mode_d  = mode_q;
        if (done_i && ack_i) begin
            // An acknowledged packet arms the endpoint to NAK until software re-arms it.
            case (mode_q)
                UEBC_MODE_ACK_OUT: mode_d = UEBC_MODE_NAK_OUT;
                UEBC_MODE_ACK_IN:  mode_d = UEBC_MODE_NAK_IN;
                default:           mode_d = mode_q;
            endcase
        end
        if (wr_i) begin
            // Bit 6 is reserved and the acked flag is not writable.
            stall_d = wdata_i[`UEBC_EP_STALL_BIT];
            naken_d = wdata_i[`UEBC_EP_NAKEN_BIT];
            mode_d  = wdata_i[`UEBC_EP_MODE_MSB:`UEBC_EP_MODE_LSB];
        end
        if (rd_i) begin
            acked_d = 1'b0;
        end
        if (done_i && ack_i) begin
            acked_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            stall_q <= EP_RST_VAL[`UEBC_EP_STALL_BIT];
            naken_q <= 1'b0;
            acked_q <= 1'b0;
            mode_q  <= 4'h0;
        end else begin
            stall_q <= stall_d;
            naken_q <= naken_d;
            acked_q <= acked_d;
            mode_q  <= mode_d;
        end
    end

    assign ctrl_o  = {stall_q, 1'b0, naken_q, acked_q, mode_q};
    assign event_o = done_i && (ack_i || (nak_i && naken_q));

endmodule : uebc_ep_ctrl

// file: testbench/uebc_top_properties.sv
`timescale 1ns/10ps
`include "uebc_regs.svh"

module uebc_top_properties (
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Engine, pads and control outputs
    input wire logic       sie_tok_valid_i,
    input wire logic       sie_done_valid_i,
    input wire logic       sie_hs_valid_o,
    input wire logic       dplus_out_level_o,
    input wire logic       dminus_out_level_o,
    input wire logic       se0_receive_out_o,
    input wire logic       usb_clk_en_o,
    input wire logic       osc_accuracy_boost_o,
    input wire logic [7:0] osc_trim_o
);
    logic misc_wr;
    logic se_d;
    logic se_q;

    assign misc_wr = reg_wr_i && reg_addr_i == `UEBC_MISC_OFS;

    // The enable bit is internal, so it is mirrored from the register writes.
    always_comb begin
        se_d = misc_wr ? reg_wdata_i[`UEBC_MISC_SEEN_BIT] : se_q;
    end

    always_ff @(posedge sys_clk_i) begin
        se_q <= sys_rst_i ? 1'b0 : se_d;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_clk_gate: assert property (misc_wr |=> usb_clk_en_o == $past(reg_wdata_i[0]))
        else $error("clock enable does not follow the control write");
    chk_boost_bit: assert property (misc_wr |=> osc_accuracy_boost_o == $past(reg_wdata_i[1]))
        else $error("boost output does not follow the control write");
    chk_trim_open: assert property (reg_wr_i && reg_addr_i == `UEBC_OSC_TRIM_OFS
        |=> osc_trim_o == $past(reg_wdata_i))
        else $error("trim write was not taken");
    chk_pad_off: assert property (!se_q [*2]
        |-> dplus_out_level_o && dminus_out_level_o && !se0_receive_out_o)
        else $error("pad outputs not parked while disabled");
    chk_gate_quiet: assert property (sie_tok_valid_i && !usb_clk_en_o |=> !sie_hs_valid_o)
        else $error("answer given while clocks are gated");
    chk_hs_cause: assert property (sie_hs_valid_o |-> $past(sie_tok_valid_i))
        else $error("answer without a token one cycle before");
    chk_line_ones: assert property (reg_rd_i && reg_addr_i == `UEBC_IO_CTRL1_OFS && !se_q
        |=> reg_rdata_o[1:0] == 2'b11)
        else $error("line state not both ones while disabled");
    chk_read_clear: assert property (
        (reg_rd_i && reg_addr_i[7:3] == 5'h02 && !sie_done_valid_i) ##1
        (reg_rd_i && $stable(reg_addr_i)) |=> !reg_rdata_o[`UEBC_EP_ACKED_BIT])
        else $error("acked flag survived a read");
endmodule : uebc_top_properties

bind uebc_top uebc_top_properties chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sie_tok_valid_i(sie_tok_valid_i),
    .sie_done_valid_i(sie_done_valid_i), .sie_hs_valid_o(sie_hs_valid_o),
    .dplus_out_level_o(dplus_out_level_o), .dminus_out_level_o(dminus_out_level_o),
    .se0_receive_out_o(se0_receive_out_o), .usb_clk_en_o(usb_clk_en_o),
    .osc_accuracy_boost_o(osc_accuracy_boost_o), .osc_trim_o(osc_trim_o));

// file: testbench/uebc_host_model.sv
`timescale 1ns/10ps

module uebc_host_model (
    // Clock
    input  wire logic       sys_clk_i,
    // Token and completion pulses
    output logic            tok_valid_o,
    output logic [2:0]      tok_ep_o,
    output logic            tok_in_o,
    output logic            done_valid_o,
    output logic [2:0]      done_ep_o,
    output logic            done_ack_o,
    output logic            done_nak_o,
    // Bus levels
    output logic            dp_o,
    output logic            dm_o
);
    initial begin
        {tok_valid_o, tok_ep_o, tok_in_o} = 5'h00;
        {done_valid_o, done_ep_o, done_ack_o, done_nak_o} = 6'h00;
        {dp_o, dm_o} = 2'b10;
    end

    // Qualifiers flip outside a pulse so stale values never pass for valid ones.
    task automatic token(input logic [2:0] ep, input logic in);
        @(posedge sys_clk_i);
        {tok_valid_o, tok_ep_o, tok_in_o} <= {1'b1, ep, in};
        @(posedge sys_clk_i);
        {tok_valid_o, tok_ep_o, tok_in_o} <= {1'b0, ~ep, ~in};
    endtask : token

    task automatic done(input logic [2:0] ep, input logic ack, input logic nak);
        @(posedge sys_clk_i);
        {done_valid_o, done_ep_o, done_ack_o, done_nak_o} <= {1'b1, ep, ack, nak};
        @(posedge sys_clk_i);
        {done_valid_o, done_ep_o, done_ack_o, done_nak_o} <= {1'b0, ~ep, ~ack, ~nak};
    endtask : done

    task automatic line(input logic p, input logic m);
        @(posedge sys_clk_i);
        {dp_o, dm_o} <= {p, m};
    endtask : line
endmodule : uebc_host_model

// file: testbench/uebc_top_tb.sv
`timescale 1ns/10ps
`include "uebc_regs.svh"

`define CHK(n, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
    end \
end

module uebc_top_tb
    import uebc_pkg::*;
;
    logic       sys_clk_i   = 1'b0;
    logic       sys_rst_i   = 1'b1;
    logic [7:0] reg_addr_i  = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i    = 1'b0;
    logic       reg_rd_i    = 1'b0;
    logic [7:0] rdata, trim, trim2, d1, d2;
    logic [2:0] tok_ep, done_ep;
    logic [1:0] hs_code;
    logic       tok_v, tok_in, done_v, done_ack, done_nak, dp, dm;
    logic       hs_v, dplus_out_level, dminus_out_level, se0, clk_en, boost, irq;
    int         errors      = 0;
    int         comparisons = 0;
    int         cycles      = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    uebc_host_model host (.sys_clk_i(sys_clk_i), .tok_valid_o(tok_v), .tok_ep_o(tok_ep),
        .tok_in_o(tok_in), .done_valid_o(done_v), .done_ep_o(done_ep), .done_ack_o(done_ack),
        .done_nak_o(done_nak), .dp_o(dp), .dm_o(dm));

    uebc_top DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata), .sie_tok_valid_i(tok_v), .sie_tok_ep_i(tok_ep),
        .sie_tok_in_i(tok_in), .sie_done_valid_i(done_v), .sie_done_ep_i(done_ep),
        .sie_done_ack_i(done_ack), .sie_done_nak_i(done_nak), .sie_hs_valid_o(hs_v),
        .sie_hs_code_o(hs_code), .usb_dp_i(dp), .usb_dm_i(dm), .dplus_out_level_o(dplus_out_level),
        .dminus_out_level_o(dminus_out_level), .se0_receive_out_o(se0), .usb_clk_en_o(clk_en),
        .osc_accuracy_boost_o(boost), .osc_trim_o(trim), .osc_trim_two_o(trim2), .irq_o(irq));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Two back-to-back reads of one address, the second one seeing the first one's side effect.
    task automatic rd_twice(input logic [7:0] a, output logic [7:0] x, output logic [7:0] y);
        @(posedge sys_clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge sys_clk_i);
        #1 x = rdata;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 y = rdata;
    endtask : rd_twice

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : settle

    task automatic tok(input logic [2:0] ep, input logic in, input logic v, input logic [1:0] c);
        host.token(ep, in);
        #1;
        `CHK("hs_valid", v, hs_v);
        if (v) `CHK("hs_code", c, hs_code);
    endtask : tok

    task automatic t_reset();
        #1;
        `CHK("pads", 3'b110, {dplus_out_level, dminus_out_level, se0});
        `CHK("clk_en", 1'b0, clk_en);
        rd(`UEBC_MISC_OFS, d1);
        `CHK("misc", 8'h00, d1);
        rd(`UEBC_EP_BASE_OFS, d1);
        `CHK("ep0", 8'h00, d1);
        rd(`UEBC_IO_CTRL1_OFS, d1);
        `CHK("line", 2'b11, d1[1:0]);
        rd(8'h7F, d1);
        `CHK("unmapped", 8'h00, d1);
        $display("done t_reset");
    endtask : t_reset

    task automatic t_gated();
        wr(`UEBC_EP_BASE_OFS + 8'h01, 8'h82);
        rd(`UEBC_EP_BASE_OFS + 8'h01, d1);
        `CHK("ep1 gated", 8'h00, d1);
        wr(`UEBC_OSC_TRIM_OFS, 8'h5A);
        `CHK("trim", 8'h5A, trim);
        wr(`UEBC_OSC_TRIM2_OFS, 8'hA5);
        `CHK("trim2", 8'hA5, trim2);
        tok(3'h1, 1'b0, 1'b0, UEBC_HS_ACK);
        $display("done t_gated");
    endtask : t_gated

    task automatic t_enable();
        wr(`UEBC_MISC_OFS, 8'h05);
        `CHK("clk_en", 1'b1, clk_en);
        `CHK("boost low", 1'b0, boost);
        wr(`UEBC_MISC_OFS, 8'h07);
        `CHK("boost high", 1'b1, boost);
        rd(`UEBC_MISC_OFS, d1);
        `CHK("misc", 8'h07, d1);
        $display("done t_enable");
    endtask : t_enable

    task automatic t_stall();
        wr(`UEBC_EP_BASE_OFS + 8'h01, 8'h82);
        wr(`UEBC_EP_BASE_OFS + 8'h02, 8'h84);
        wr(`UEBC_EP_BASE_OFS + 8'h03, 8'h02);
        tok(3'h1, 1'b0, 1'b1, UEBC_HS_STALL);
        tok(3'h1, 1'b1, 1'b0, UEBC_HS_ACK);
        tok(3'h2, 1'b1, 1'b1, UEBC_HS_STALL);
        tok(3'h3, 1'b0, 1'b1, UEBC_HS_ACK);
        host.done(3'h3, 1'b1, 1'b0);
        rd_twice(`UEBC_EP_BASE_OFS + 8'h03, d1, d2);
        `CHK("ep3 acked", 8'h11, d1);
        `CHK("ep3 cleared", 8'h01, d2);
        tok(3'h3, 1'b0, 1'b1, UEBC_HS_NAK);
        $display("done t_stall");
    endtask : t_stall

    task automatic t_irq();
        wr(`UEBC_INT_STAT_OFS, 8'hFF);
        wr(`UEBC_INT_MASK_OFS, 8'h70);
        wr(`UEBC_EP_BASE_OFS + 8'h04, 8'h03);
        wr(`UEBC_EP_BASE_OFS + 8'h05, 8'h23);
        wr(`UEBC_EP_BASE_OFS + 8'h07, 8'h02);
        tok(3'h5, 1'b1, 1'b1, UEBC_HS_NAK);
        host.done(3'h4, 1'b0, 1'b1);
        settle(2);
        `CHK("irq nak quiet", 1'b0, irq);
        host.done(3'h5, 1'b0, 1'b1);
        settle(2);
        `CHK("irq nak", 1'b1, irq);
        rd(`UEBC_INT_STAT_OFS, d1);
        `CHK("status nak", 8'h20, d1);
        wr(`UEBC_INT_STAT_OFS, 8'h20);
        settle(2);
        `CHK("irq cleared", 1'b0, irq);
        host.done(3'h7, 1'b1, 1'b0);
        settle(2);
        `CHK("irq masked", 1'b0, irq);
        rd(`UEBC_INT_STAT_OFS, d1);
        `CHK("status ack", 8'h80, d1);
        wr(`UEBC_INT_MASK_OFS, 8'hF0);
        settle(2);
        `CHK("irq unmasked", 1'b1, irq);
        $display("done t_irq");
    endtask : t_irq

    task automatic t_pad();
        host.line(1'b1, 1'b0);
        settle(5);
        `CHK("pads j", 3'b100, {dplus_out_level, dminus_out_level, se0});
        rd(`UEBC_IO_CTRL1_OFS, d1);
        `CHK("line j", 2'b10, d1[1:0]);
        host.line(1'b0, 1'b0);
        settle(5);
        `CHK("pads se0", 3'b001, {dplus_out_level, dminus_out_level, se0});
        wr(`UEBC_MISC_OFS, 8'h03);
        settle(2);
        `CHK("pads off", 3'b110, {dplus_out_level, dminus_out_level, se0});
        rd(`UEBC_IO_CTRL1_OFS, d1);
        `CHK("line off", 2'b11, d1[1:0]);
        // Endpoint 7 sits in a NAK mode here, so only the gate keeps it silent.
        wr(`UEBC_MISC_OFS, 8'h00);
        `CHK("clk_en off", 1'b0, clk_en);
        tok(3'h7, 1'b0, 1'b0, UEBC_HS_NAK);
        host.done(3'h5, 1'b0, 1'b1);
        wr(`UEBC_INT_STAT_OFS, 8'h80);
        settle(2);
        `CHK("irq gated", 1'b1, irq);
        rd(`UEBC_INT_STAT_OFS, d1);
        `CHK("status gated", 8'h80, d1);
        $display("done t_pad");
    endtask : t_pad

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // The whole sequence needs well under a thousand cycles.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("timeout after %0d cycles", cycles);
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_gated();
        t_enable();
        t_stall();
        t_irq();
        t_pad();
        final_report();
    end
endmodule : uebc_top_tb
